// File: logic/omcr_pkg.sv
// Purpose: Constants and types of the operating mode control register bank
// Assumes: 8-bit registers on a byte address, 100 MHz clock
// Notes:   Shared by the design and by the bench
package omcr_pkg;

  // Register byte offsets
  localparam logic [7:0] OMCR_ADDR_MODE_CTL   = 8'h0a;
  localparam logic [7:0] OMCR_ADDR_INTV_HIGH  = 8'h0b;
  localparam logic [7:0] OMCR_ADDR_INTV_LOW   = 8'h0c;
  localparam logic [7:0] OMCR_ADDR_LIMIT_HIGH = 8'h0d;
  localparam logic [7:0] OMCR_ADDR_LIMIT_LOW  = 8'h0e;
  localparam logic [7:0] OMCR_ADDR_EVT_STATUS = 8'h20;
  localparam logic [7:0] OMCR_ADDR_EVT_MASK   = 8'h21;
  localparam logic [7:0] OMCR_ADDR_RUN_STATE  = 8'h22;

  // Reset values
  localparam logic [7:0] OMCR_RST_MODE_CTL   = 8'h00;
  localparam logic [7:0] OMCR_RST_INTV_HIGH  = 8'h80;
  localparam logic [7:0] OMCR_RST_INTV_LOW   = 8'h00;
  localparam logic [7:0] OMCR_RST_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] OMCR_RST_LIMIT_LOW  = 8'h00;
  localparam logic [7:0] OMCR_RST_EVT        = 8'h00;

  // Operating mode codes of the two-bit mode field
  localparam logic [1:0] OMCR_MODE_NORMAL1  = 2'h0;
  localparam logic [1:0] OMCR_MODE_NORMAL2  = 2'h1;
  localparam logic [1:0] OMCR_MODE_STANDBY1 = 2'h2;
  localparam logic [1:0] OMCR_MODE_STANDBY2 = 2'h3;

  // Ignored data cycles: code 0 means this many cycles
  localparam logic [3:0] OMCR_IGNORE_BASE = 4'h3;

  // Interval unit bit: 0 milliseconds, 1 seconds
  localparam int OMCR_UNIT_BIT = 7;

  // Event bit positions in status and mask
  localparam int OMCR_EVT_WAKE_REQ  = 0;
  localparam int OMCR_EVT_SAMPLE    = 1;
  localparam int OMCR_EVT_TO_NORMAL = 2;
  localparam int OMCR_EVT_NUM       = 3;

  // Timing
  localparam int OMCR_CLK_PERIOD_NS = 10;
  localparam int OMCR_MS_NS         = 1000000;
  localparam int OMCR_CYC_PER_MS    = OMCR_MS_NS / OMCR_CLK_PERIOD_NS;
  localparam logic [9:0] OMCR_MS_PER_S = 10'h03e8;

  // Mode control register layout, msb first
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] ignore_code;
    logic       chop_en;
    logic       wake_en;
    logic       release_run;
  } omcr_mode_ctl_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } omcr_bus_req_t;

  // Measurement result from the acquisition path
  typedef struct packed {
    logic        valid;
    logic [15:0] current;
  } omcr_result_t;

  typedef enum logic [2:0] {
    OMCR_ST_STOP,
    OMCR_ST_NORMAL1,
    OMCR_ST_NORMAL2,
    OMCR_ST_STANDBY1,
    OMCR_ST_STANDBY2
  } omcr_state_t;

endpackage

// File: logic/omcr_top.sv
// Purpose: Operating mode and standby supervision control registers
// Assumes: Result and chopper source come from logic on the same clock
// Notes:   Registers reached over a plain strobe port, read data next cycle
`timescale 1ns/10ps
module omcr_top #(
  parameter int CYC_PER_MS = omcr_pkg::OMCR_CYC_PER_MS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire omcr_pkg::omcr_bus_req_t bus_req,
  output logic [7:0]                  rdata,
  input  wire omcr_pkg::omcr_result_t result,
  input  wire logic                   chopper_clock_output_src,
  output logic                        chopper_clock_output,
  output logic                        wake_indicator_pin,
  output logic                        sample_start,
  output omcr_pkg::omcr_state_t       run_state,
  output logic                        irq
);
  import omcr_pkg::*;

  // Register storage
  omcr_mode_ctl_t mode_ctl_q;
  logic [7:0]     intv_high_q;
  logic [7:0]     intv_low_q;
  logic [7:0]     limit_high_q;
  logic [7:0]     limit_low_q;
  logic [OMCR_EVT_NUM-1:0] evt_status_q;
  logic [OMCR_EVT_NUM-1:0] evt_mask_q;
  logic [7:0]     rdata_q;

  // Sequencing state
  omcr_state_t state_q;
  omcr_state_t state_d;
  logic [3:0]  ignore_cnt_q;
  logic [31:0] ms_cnt_q;
  logic [9:0]  sec_cnt_q;
  logic [14:0] intv_cnt_q;
  logic        wake_flag_q;
  logic        chop_q;
  logic        sample_q;

  // Address decode
  wire logic hit_mode  = bus_req.addr == OMCR_ADDR_MODE_CTL;
  wire logic hit_ih    = bus_req.addr == OMCR_ADDR_INTV_HIGH;
  wire logic hit_il    = bus_req.addr == OMCR_ADDR_INTV_LOW;
  wire logic hit_lh    = bus_req.addr == OMCR_ADDR_LIMIT_HIGH;
  wire logic hit_ll    = bus_req.addr == OMCR_ADDR_LIMIT_LOW;
  wire logic hit_stat  = bus_req.addr == OMCR_ADDR_EVT_STATUS;
  wire logic hit_mask  = bus_req.addr == OMCR_ADDR_EVT_MASK;
  wire logic hit_state = bus_req.addr == OMCR_ADDR_RUN_STATE;
  wire logic wr_mode   = bus_req.we && hit_mode;
  wire logic wr_stat   = bus_req.we && hit_stat;
  wire logic wr_ih     = bus_req.we && hit_ih;
  wire logic wr_il     = bus_req.we && hit_il;
  wire logic wr_lh     = bus_req.we && hit_lh;
  wire logic wr_ll     = bus_req.we && hit_ll;
  wire logic wr_mask   = bus_req.we && hit_mask;

  // Derived register fields
  wire logic        unit_seconds = intv_high_q[OMCR_UNIT_BIT];
  wire logic [14:0] intv_value   = {intv_high_q[6:0], intv_low_q};
  wire logic [15:0] limit_value  = {limit_high_q, limit_low_q};
  wire logic [3:0]  ignore_need  =
    OMCR_IGNORE_BASE + {1'b0, mode_ctl_q.ignore_code};

  wire logic in_standby = (state_q == OMCR_ST_STANDBY1) ||
                          (state_q == OMCR_ST_STANDBY2);
  wire logic in_normal  = (state_q == OMCR_ST_NORMAL1) ||
                          (state_q == OMCR_ST_NORMAL2);
  wire logic to_normal  = in_standby &&
                          ((state_d == OMCR_ST_NORMAL1) ||
                           (state_d == OMCR_ST_NORMAL2));
  wire logic mode_change = state_d != state_q;

  // Interval time base
  wire logic ms_tick   = ms_cnt_q == 32'(CYC_PER_MS - 1);
  wire logic sec_tick  = ms_tick && (sec_cnt_q == OMCR_MS_PER_S - 10'h001);
  wire logic unit_tick = unit_seconds ? sec_tick : ms_tick;
  wire logic intv_done = unit_tick && (intv_cnt_q >= intv_value);
  wire logic sample_d  = in_standby && !mode_change && intv_done;

  // Threshold comparison after the discarded cycles
  wire logic settled   = ignore_cnt_q >= ignore_need;
  wire logic wake_hit  = (state_q == OMCR_ST_STANDBY2) && result.valid &&
                         settled &&
                         (result.current >= limit_value);

  wire logic [OMCR_EVT_NUM-1:0] evt_set;
  assign evt_set[OMCR_EVT_WAKE_REQ]  = wake_hit;
  assign evt_set[OMCR_EVT_SAMPLE]    = sample_d;
  assign evt_set[OMCR_EVT_TO_NORMAL] = to_normal;

  // Wake flag: a set in the same cycle as a clear wins
  wire logic wake_set  = wake_hit || to_normal;
  wire logic wake_clr  = wr_mode || (in_standby && !mode_change);

  // Next run state follows the release bit and the mode field
  always_comb begin
    state_d = state_q;
    if (!mode_ctl_q.release_run) begin
      state_d = OMCR_ST_STOP;
    end else begin
      case (mode_ctl_q.mode)
        OMCR_MODE_NORMAL1:  state_d = OMCR_ST_NORMAL1;
        OMCR_MODE_NORMAL2:  state_d = OMCR_ST_NORMAL2;
        OMCR_MODE_STANDBY1: state_d = OMCR_ST_STANDBY1;
        OMCR_MODE_STANDBY2: state_d = OMCR_ST_STANDBY2;
        default:            state_d = OMCR_ST_STOP;
      endcase
    end
  end

  // Read data selection
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (1'b1)
      hit_mode:  rd_mux = mode_ctl_q;
      hit_ih:    rd_mux = intv_high_q;
      hit_il:    rd_mux = intv_low_q;
      hit_lh:    rd_mux = limit_high_q;
      hit_ll:    rd_mux = limit_low_q;
      hit_stat:  rd_mux = {5'h00, evt_status_q};
      hit_mask:  rd_mux = {5'h00, evt_mask_q};
      hit_state: rd_mux = {5'h00, state_q};
      default:   rd_mux = 8'h00;
    endcase
  end

  // Register writes, one short process per register
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ctl_q <= OMCR_RST_MODE_CTL;
    end else if (ce && wr_mode) begin
      mode_ctl_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intv_high_q <= OMCR_RST_INTV_HIGH;
    end else if (ce && wr_ih) begin
      intv_high_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intv_low_q <= OMCR_RST_INTV_LOW;
    end else if (ce && wr_il) begin
      intv_low_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      limit_high_q <= OMCR_RST_LIMIT_HIGH;
    end else if (ce && wr_lh) begin
      limit_high_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      limit_low_q <= OMCR_RST_LIMIT_LOW;
    end else if (ce && wr_ll) begin
      limit_low_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt_mask_q <= OMCR_RST_EVT[OMCR_EVT_NUM-1:0];
    end else if (ce && wr_mask) begin
      evt_mask_q <= bus_req.wdata[OMCR_EVT_NUM-1:0];
    end
  end

  // Sticky events: a new event wins over a write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < OMCR_EVT_NUM; gi++) begin : g_evt
      always_ff @(posedge clk) begin
        if (rst) begin
          evt_status_q[gi] <= 1'b0;
        end else if (ce) begin
          if (evt_set[gi]) begin
            evt_status_q[gi] <= 1'b1;
          end else if (wr_stat && bus_req.wdata[gi]) begin
            evt_status_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Read data, valid in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (ce && bus_req.re) begin
      rdata_q <= rd_mux;
    end
  end

  // Run state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= OMCR_ST_STOP;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Discarded data cycles, restarted on each entry into a mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ignore_cnt_q <= 4'h0;
    end else if (ce) begin
      if (mode_change || !in_standby) begin
        ignore_cnt_q <= 4'h0;
      end else if (result.valid && !settled) begin
        ignore_cnt_q <= ignore_cnt_q + 4'h1;
      end
    end
  end

  // Millisecond prescaler, runs only in standby
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (!in_standby || mode_change || ms_tick) begin
        ms_cnt_q <= 32'h0000_0000;
      end else begin
        ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Second prescaler counts millisecond ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_cnt_q <= 10'h000;
    end else if (ce) begin
      if (!in_standby || mode_change || sec_tick) begin
        sec_cnt_q <= 10'h000;
      end else if (ms_tick) begin
        sec_cnt_q <= sec_cnt_q + 10'h001;
      end
    end
  end

  // One sample start each time the interval elapses
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_q <= 1'b0;
    end else if (ce) begin
      sample_q <= sample_d;
    end
  end

  // Interval counter in units, restarted on each mode entry
  always_ff @(posedge clk) begin
    if (rst) begin
      intv_cnt_q <= 15'h0000;
    end else if (ce) begin
      if (!in_standby || mode_change || intv_done) begin
        intv_cnt_q <= 15'h0000;
      end else if (unit_tick) begin
        intv_cnt_q <= intv_cnt_q + 15'h0001;
      end
    end
  end

  // Wake indication: raised by a threshold hit or a return from standby to normal
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_flag_q <= 1'b0;
    end else if (ce) begin
      if (wake_set) begin
        wake_flag_q <= 1'b1;
      end else if (wake_clr) begin
        wake_flag_q <= 1'b0;
      end
    end
  end

  // Chopper clock gate
  always_ff @(posedge clk) begin
    if (rst) begin
      chop_q <= 1'b0;
    end else if (ce) begin
      chop_q <= chopper_clock_output_src && mode_ctl_q.chop_en;
    end
  end

  assign rdata                = rdata_q;
  assign chopper_clock_output = chop_q;
  assign wake_indicator_pin   = wake_flag_q && mode_ctl_q.wake_en;
  assign sample_start         = sample_q;
  assign run_state            = state_q;
  assign irq                  = |(evt_status_q & evt_mask_q);

endmodule

// File: tb/omcr_assertions.sv
// Purpose: Port checks of the mode control register bank
// Assumes: ce held high outside reset
// Notes:   Mode and mask registers mirrored from bus writes
`timescale 1ns/10ps
module omcr_assertions #(
  parameter int CYC_PER_MS = omcr_pkg::OMCR_CYC_PER_MS
) (
  input logic                    clk,
  input logic                    rst,
  input logic                    ce,
  input omcr_pkg::omcr_bus_req_t bus_req,
  input logic [7:0]              rdata,
  input omcr_pkg::omcr_result_t  result,
  input logic                    chopper_clock_output_src,
  input logic                    chopper_clock_output,
  input logic                    wake_indicator_pin,
  input logic                    sample_start,
  input omcr_pkg::omcr_state_t   run_state,
  input logic                    irq
);
  import omcr_pkg::*;
  logic [7:0] mode_q;
  logic [2:0] mask_q;
  wire        wr_hit = ce && bus_req.we;
  wire        rd_hit = ce && bus_req.re;
  wire        unmapped = !(bus_req.addr inside
                {[8'h0a:8'h0e], [8'h20:8'h22]});

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= 8'h00;
      mask_q <= 3'h0;
    end else if (wr_hit) begin
      if (bus_req.addr == OMCR_ADDR_MODE_CTL) mode_q <= bus_req.wdata;
      if (bus_req.addr == OMCR_ADDR_EVT_MASK) mask_q <= bus_req.wdata[2:0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_mode_wr;
    wr_hit && bus_req.addr == OMCR_ADDR_MODE_CTL;
  endsequence

  a_stop_hold: assert property (
    s_mode_wr ##0 !bus_req.wdata[0] |-> ##2 run_state == OMCR_ST_STOP)
    else $error("run state left stop");
  a_mode_select: assert property (
    s_mode_wr ##0 bus_req.wdata[0] |->
    ##2 run_state == {1'b0, $past(bus_req.wdata[7:6], 2)} + 3'h1)
    else $error("wrong run state for mode field");
  a_chop_gate: assert property (
    $stable(mode_q[2]) |->
    chopper_clock_output == (mode_q[2] && $past(chopper_clock_output_src)))
    else $error("chopper output not gated by enable");
  a_wake_gate: assert property (
    !mode_q[1] |-> !wake_indicator_pin)
    else $error("wake pin high while disabled");
  a_read_mode: assert property (
    rd_hit && bus_req.addr == OMCR_ADDR_MODE_CTL |=> rdata == $past(mode_q))
    else $error("mode register read back wrong");
  a_read_unmap: assert property (
    rd_hit && unmapped |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (
    mask_q == 3'h0 |-> !irq)
    else $error("interrupt with all events masked");
  a_sample_pulse: assert property (
    sample_start |-> $past(run_state) inside
    {OMCR_ST_STANDBY1, OMCR_ST_STANDBY2} ##1 !sample_start)
    else $error("sample pulse outside standby or too long");
endmodule

bind omcr_top omcr_assertions #(.CYC_PER_MS(CYC_PER_MS)) chk (.clk, .rst,
  .ce, .bus_req, .rdata, .result, .chopper_clock_output_src, .chopper_clock_output,
  .wake_indicator_pin, .sample_start, .run_state, .irq);

// File: tb/omcr_acq_model.sv
// Purpose: Acquisition path model feeding results and chopper source
// Assumes: Same clock as the register bank
// Notes:   Current shows a changing pattern between results
`timescale 1ns/10ps
module omcr_acq_model (
  input  logic                   clk,
  input  logic                   rst,
  input  logic                   fire,
  input  logic [15:0]            level,
  output omcr_pkg::omcr_result_t result,
  output logic                   chopper_clock_output_src
);
  import omcr_pkg::*;
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= '0;
      chopper_clock_output_src <= 1'b0;
    end else begin
      chopper_clock_output_src <= !chopper_clock_output_src;
      result.valid <= fire;
      result.current <= fire ? level : ~result.current;
    end
  end
endmodule

// File: tb/omcr_top_test.sv
// Purpose: Register bank test through its strobe port
// Assumes: Millisecond prescale shortened to 4 cycles
// Notes:   Each wait is a bounded loop
`timescale 1ns/10ps
module omcr_top_test;
  import omcr_pkg::*;
  logic          clk, rst, ce, fire, chopper_clock_output_src, irq;
  logic          chopper_clock_output, wake_indicator_pin, sample_start;
  logic [15:0]   level;
  logic [7:0]    rdata;
  omcr_bus_req_t bus_req;
  omcr_result_t  result;
  omcr_state_t   run_state;
  int            mismatches, cmp_count, ones;
  logic [7:0]    ra [5] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
  logic [7:0]    rv [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

  omcr_top #(.CYC_PER_MS(4)) uut (.clk, .rst, .ce, .bus_req, .rdata,
    .result, .chopper_clock_output_src, .chopper_clock_output, .wake_indicator_pin,
    .sample_start, .run_state, .irq);
  omcr_acq_model acq (.clk, .rst, .fire, .level, .result, .chopper_clock_output_src);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus_req.we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus_req.re <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [15:0] v);
    @(posedge clk);
    fire <= 1'b1;
    level <= v;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // Cycles between two successive sample pulses
  task automatic gap(input int exp);
    int t0, i;
    t0 = -1;
    for (i = 0; i < 9000; i++) begin
      cyc(1);
      if (sample_start === 1'b1) begin
        if (t0 >= 0) break;
        t0 = i;
      end
    end
    if (i == 9000) begin
      mismatches++;
      $display("mismatch at %0t: no sample pulse", $time);
      final_report();
    end else
      chk(16'(i - t0), 16'(exp));
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    fire = 1'b0;
    level = 16'h0000;
    bus_req = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[k]) rd(ra[k], rv[k]);
    rd(8'h0f, 8'h00);
    for (int k = 1; k < 5; k++) begin
      wr(ra[k], 8'h5a ^ 8'(k));
      rd(ra[k], 8'h5a ^ 8'(k));
    end
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h0a, {m[1:0], 6'h00});
      cyc(1);
      chk(run_state, 16'h0000);
      wr(8'h0a, {m[1:0], 6'h01});
      cyc(1);
      chk(run_state, 16'(m + 1));
    end
    for (int e = 0; e < 2; e++) begin
      wr(8'h0a, {5'h00, e[0], 2'h0});
      cyc(2);
      ones = 0;
      repeat (4) begin
        cyc(1);
        ones += chopper_clock_output;
      end
      chk(16'(ones), 16'(2 * e));
    end
    wr(8'h0d, 8'h10);
    wr(8'h0e, 8'h00);
    for (int c = 0; c < 8; c += 7) begin
      wr(8'h0a, 8'h00);
      wr(8'h20, 8'h07);
      wr(8'h0a, {2'b11, c[2:0], 3'b011});
      cyc(3);
      repeat (c + 3) send(16'h1000);
      send(16'h0fff);
      cyc(1);
      chk(wake_indicator_pin, 16'h0000);
      rd(8'h20, 8'h00);
      send(16'h1000);
      cyc(1);
      chk(wake_indicator_pin, 16'h0001);
      rd(8'h20, 8'h01);
    end
    wr(8'h21, 8'h01);
    chk(irq, 16'h0001);
    wr(8'h20, 8'h01);
    chk(irq, 16'h0000);
    wr(8'h0a, 8'h03);
    cyc(4);
    chk(wake_indicator_pin, 16'h0001);
    wr(8'h21, 8'h04);
    chk(irq, 16'h0001);
    wr(8'h0a, 8'hc1);
    cyc(3);
    wr(8'h0a, 8'h01);
    cyc(4);
    chk(wake_indicator_pin, 16'h0000);
    wr(8'h0b, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h0a, 8'h81);
    gap(8);
    wr(8'h0a, 8'h01);
    wr(8'h0b, 8'h80);
    wr(8'h0c, 8'h00);
    wr(8'h0a, 8'h81);
    gap(4000);
    final_report();
  end
endmodule
